// ### occ_load_model.sv
// External load hanging on the compare output pin.
// Assumes a board pull-down holds the line while the channel lets go.
module occ_load_model (
    // Clock
    input wire logic clk_sys,
    // Pin from the channel
    input wire logic compare_output_pin,
    input wire logic pin_drive_en,
    // Level the load sees
    output logic load_level
);
    timeunit 1ns;
    timeprecision 100ps;
    // Released line sinks to the pull-down, not the last driven level
    always_ff @(posedge clk_sys) begin
        load_level <= pin_drive_en ? compare_output_pin : 1'b0;
    end
endmodule // occ_load_model

// ### occ_map.svh
// Address map, field positions, reset values and mode codes of the
// output compare channel. Assumes byte addressing over a 32-bit APB.
`ifndef OCC_MAP_SVH
`define OCC_MAP_SVH

`define OCC_ADDR_W 8
`define OCC_ADDR_CTRL 8'h00
`define OCC_ADDR_PRI 8'h04
`define OCC_ADDR_SEC 8'h08

`define OCC_F_MODE 2:0
`define OCC_F_TSEL 3
`define OCC_F_FLT 4
`define OCC_F_IDLE 13
`define OCC_CTRL_WMASK 16'h200f
`define OCC_CTRL_RST 16'h0000
`define OCC_ZERO16 16'h0000
`define OCC_ZERO32 32'h0000_0000

`define OCC_MODE_OFF 3'h0
`define OCC_MODE_SET_HI 3'h1
`define OCC_MODE_SET_LO 3'h2
`define OCC_MODE_TOGGLE 3'h3
`define OCC_MODE_PULSE1 3'h4
`define OCC_MODE_PULSEN 3'h5
`define OCC_MODE_PWM 3'h6
`define OCC_MODE_PWM_FLT 3'h7

`endif

// ### occ_output_compare.sv
// One output compare channel with an APB register slave.
// Assumes timer counts, idle and fault inputs are synchronous to clk_sys.
`include "occ_map.svh"

module occ_output_compare (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // APB slave
    input occ_pkg::occ_apb_req_s apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Time bases and system state
    input wire logic [15:0] timer2_count,
    input wire logic [15:0] timer3_count,
    input wire logic cpu_idle,
    input wire logic fault_input_a,
    // Compare output and event
    output logic compare_output_pin,
    output logic pin_drive_en,
    output logic compare_irq
);

    function automatic logic [1:0] occ_decode(
        input logic [`OCC_ADDR_W-1:0] addr
    );
        // 0 control, 1 primary, 2 secondary, 3 unmapped
        case (addr)
            `OCC_ADDR_CTRL: occ_decode = 2'h0;
            `OCC_ADDR_PRI: occ_decode = 2'h1;
            `OCC_ADDR_SEC: occ_decode = 2'h2;
            default: occ_decode = 2'h3;
        endcase
    endfunction

    logic [15:0] ctrl;
    logic [15:0] primary_compare_value;
    logic [15:0] secondary_compare_value;
    logic pwm_fault_flag;
    logic eq_pri_q;
    logic eq_sec_q;
    logic zero_q;
    logic fault_q;
    occ_pkg::occ_pulse_e pulse_state;
    occ_pkg::occ_pulse_e next_pulse_state;
    logic next_pin;
    logic next_irq;

    // Bus decode
    wire [1:0] sel = occ_decode(apb_req.paddr);
    wire setup = apb_req.psel & ~apb_req.penable;
    wire fire = apb_req.psel & apb_req.penable & pready;
    wire wr = fire & apb_req.pwrite & (sel != 2'h3);
    wire ctrl_wr = wr & (sel == 2'h0);
    wire pri_wr = wr & (sel == 2'h1);
    wire sec_wr = wr & (sel == 2'h2);
    wire [15:0] wdata = apb_req.pwdata[15:0];
    wire [15:0] ctrl_new = wdata & `OCC_CTRL_WMASK;
    wire [15:0] ctrl_rd = ctrl | (16'(pwm_fault_flag) << `OCC_F_FLT);
    wire [15:0] rd_mux = (sel == 2'h0) ? ctrl_rd :
                         (sel == 2'h1) ? primary_compare_value :
                         (sel == 2'h2) ? secondary_compare_value :
                         `OCC_ZERO16;

    // Mode and time base selection
    wire [2:0] compare_mode_sel = ctrl[`OCC_F_MODE];
    wire [2:0] new_mode = ctrl_new[`OCC_F_MODE];
    wire timebase_select = ctrl[`OCC_F_TSEL];
    wire idle_halt_sel = ctrl[`OCC_F_IDLE];
    wire [15:0] tmr = timebase_select ? timer3_count : timer2_count;
    wire run = ~(idle_halt_sel & cpu_idle);

    // Matches are taken once, on the count's arrival at the value,
    // so a stopped timer does not keep re-triggering.
    wire eq_pri = (tmr == primary_compare_value);
    wire eq_sec = (tmr == secondary_compare_value);
    wire match_pri = run & eq_pri & ~eq_pri_q;
    wire match_sec = run & eq_sec & ~eq_sec_q;
    wire period_start = run & (tmr == `OCC_ZERO16) & ~zero_q;
    wire is_pwm = (compare_mode_sel == `OCC_MODE_PWM) |
                  (compare_mode_sel == `OCC_MODE_PWM_FLT);
    wire flt_mode = (compare_mode_sel == `OCC_MODE_PWM_FLT);
    wire fault_fall = fault_q & ~fault_input_a;
    wire fault_event = run & flt_mode & fault_fall;
    wire pwm_load = run & is_pwm & period_start;
    wire pin_rise = next_pin & ~compare_output_pin;
    wire pin_fall = ~next_pin & compare_output_pin;

    // Pin and pulse sequencing
    always_comb begin
        next_pin = compare_output_pin;
        next_pulse_state = pulse_state;
        if (ctrl_wr) begin
            next_pulse_state = occ_pkg::PULSE_WAIT_RISE;
            case (new_mode)
                `OCC_MODE_OFF: next_pin = compare_output_pin;
                `OCC_MODE_SET_HI: next_pin = 1'b0;
                `OCC_MODE_SET_LO: next_pin = 1'b1;
                `OCC_MODE_TOGGLE: next_pin = compare_output_pin;
                `OCC_MODE_PULSE1: next_pin = 1'b0;
                `OCC_MODE_PULSEN: next_pin = 1'b0;
                default: next_pin = (primary_compare_value != `OCC_ZERO16);
            endcase
        end else begin
            case (compare_mode_sel)
                `OCC_MODE_SET_HI: begin
                    if (match_pri) next_pin = 1'b1;
                end
                `OCC_MODE_SET_LO: begin
                    if (match_pri) next_pin = 1'b0;
                end
                `OCC_MODE_TOGGLE: begin
                    if (match_pri) next_pin = ~compare_output_pin;
                end
                `OCC_MODE_PULSE1, `OCC_MODE_PULSEN: begin
                    case (pulse_state)
                        occ_pkg::PULSE_WAIT_RISE: begin
                            if (match_pri) begin
                                next_pin = 1'b1;
                                next_pulse_state = occ_pkg::PULSE_WAIT_FALL;
                            end
                        end
                        occ_pkg::PULSE_WAIT_FALL: begin
                            if (match_sec) begin
                                next_pin = 1'b0;
                                // Single pulse parks, continuous rearms
                                next_pulse_state =
                                    (compare_mode_sel == `OCC_MODE_PULSEN) ?
                                    occ_pkg::PULSE_WAIT_RISE :
                                    occ_pkg::PULSE_DONE;
                            end
                        end
                        default: next_pulse_state = occ_pkg::PULSE_DONE;
                    endcase
                end
                `OCC_MODE_PWM, `OCC_MODE_PWM_FLT: begin
                    // In flt_mode a latched fault keeps the output low
                    if (flt_mode & (pwm_fault_flag | fault_event)) begin
                        next_pin = 1'b0;
                    end else if (pwm_load) begin
                        next_pin = (secondary_compare_value != `OCC_ZERO16);
                    end else if (match_pri) begin
                        next_pin = 1'b0;
                    end
                end
                default: next_pin = compare_output_pin;
            endcase
        end
    end

    // Interrupt events per mode; setting up a mode is not an event
    always_comb begin
        next_irq = 1'b0;
        if (!ctrl_wr) begin
            case (compare_mode_sel)
                `OCC_MODE_SET_HI: next_irq = pin_rise;
                `OCC_MODE_SET_LO: next_irq = pin_fall;
                `OCC_MODE_TOGGLE: next_irq = pin_rise | pin_fall;
                `OCC_MODE_PULSE1: next_irq = pin_fall;
                `OCC_MODE_PULSEN: next_irq = pin_fall;
                `OCC_MODE_PWM: next_irq = 1'b0;
                `OCC_MODE_PWM_FLT: next_irq = fault_event;
                default: next_irq = 1'b0;
            endcase
        end
    end

    // APB answers one cycle after setup: no wait states
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `OCC_ZERO32;
        end else begin
            pready <= setup;
            pslverr <= setup & (sel == 2'h3);
            prdata <= setup ? {16'h0000, rd_mux} : `OCC_ZERO32;
        end
    end

    // Registers; software writes win over the period reload
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= `OCC_CTRL_RST;
            primary_compare_value <= `OCC_ZERO16;
            secondary_compare_value <= `OCC_ZERO16;
        end else begin
            if (ctrl_wr) ctrl <= ctrl_new;
            if (pri_wr) begin
                primary_compare_value <= wdata;
            end else if (pwm_load) begin
                primary_compare_value <= secondary_compare_value;
            end
            if (sec_wr) secondary_compare_value <= wdata;
        end
    end

    // Fault flag: set wins, cleared by hardware at a PWM period start with the fault gone
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pwm_fault_flag <= 1'b0;
        end else if (fault_event) begin
            pwm_fault_flag <= 1'b1;
        end else if (pwm_load & fault_input_a) begin
            pwm_fault_flag <= 1'b0;
        end
    end

    // Channel state and outputs
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            eq_pri_q <= 1'b0;
            eq_sec_q <= 1'b0;
            zero_q <= 1'b0;
            fault_q <= 1'b1;
            pulse_state <= occ_pkg::PULSE_WAIT_RISE;
            compare_output_pin <= 1'b0;
            pin_drive_en <= 1'b0;
            compare_irq <= 1'b0;
        end else begin
            eq_pri_q <= eq_pri;
            eq_sec_q <= eq_sec;
            zero_q <= (tmr == `OCC_ZERO16);
            fault_q <= fault_input_a;
            pulse_state <= next_pulse_state;
            compare_output_pin <= next_pin;
            pin_drive_en <= ctrl_wr ? (new_mode != `OCC_MODE_OFF) :
                            (compare_mode_sel != `OCC_MODE_OFF);
            compare_irq <= next_irq;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    property p_off_release;
        (compare_mode_sel == `OCC_MODE_OFF) && !ctrl_wr |=> !pin_drive_en;
    endproperty
    a_off_release: assert property (p_off_release)
        else $error("Pin driven while channel disabled");

    property p_set_high;
        (compare_mode_sel == `OCC_MODE_SET_HI) && !ctrl_wr && match_pri &&
        !compare_output_pin |=> compare_output_pin && compare_irq;
    endproperty
    a_set_high: assert property (p_set_high)
        else $error("Match did not raise pin with event");

    property p_set_low;
        (compare_mode_sel == `OCC_MODE_SET_LO) && !ctrl_wr && match_pri
        |=> !compare_output_pin;
    endproperty
    a_set_low: assert property (p_set_low)
        else $error("Match did not lower pin");

    property p_toggle;
        (compare_mode_sel == `OCC_MODE_TOGGLE) && !ctrl_wr && match_pri
        |=> compare_output_pin != $past(compare_output_pin) && compare_irq;
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("Match did not invert pin");

    property p_pulse_fall_irq;
        $fell(compare_output_pin) &&
        ($past(compare_mode_sel) == `OCC_MODE_PULSEN) &&
        !$past(ctrl_wr) |-> compare_irq;
    endproperty
    a_pulse_fall_irq: assert property (p_pulse_fall_irq)
        else $error("Pulse fall gave no event");

    property p_pwm_quiet;
        (compare_mode_sel == `OCC_MODE_PWM) && !ctrl_wr |=> !compare_irq;
    endproperty
    a_pwm_quiet: assert property (p_pwm_quiet)
        else $error("Event raised in plain PWM mode");

    property p_fault_latch;
        fault_event && !ctrl_wr |=> pwm_fault_flag && !compare_output_pin
        && compare_irq;
    endproperty
    a_fault_latch: assert property (p_fault_latch)
        else $error("Fault not latched");

    // Halted channel holds its pin in every mode but faulted PWM
    property p_idle_hold;
        !run && !ctrl_wr && !flt_mode
        |=> $stable(compare_output_pin);
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("Pin moved while halted in idle");

    property p_unused_zero;
        setup && (sel == 2'h0) |=> prdata[15:14] == 2'h0
        && prdata[12:5] == 8'h00 && pready;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("Unused control bits read nonzero");

    property p_pulse_rise;
        (compare_mode_sel == `OCC_MODE_PULSE1 ||
         compare_mode_sel == `OCC_MODE_PULSEN) && !ctrl_wr &&
        pulse_state == occ_pkg::PULSE_WAIT_RISE && match_pri
        |=> compare_output_pin && !compare_irq;
    endproperty
    a_pulse_rise: assert property (p_pulse_rise)
        else $error("Pulse did not rise on primary match");

    property p_init_low;
        ctrl_wr && (new_mode == `OCC_MODE_SET_HI ||
        new_mode == `OCC_MODE_PULSE1 || new_mode == `OCC_MODE_PULSEN)
        |=> !compare_output_pin && pin_drive_en && !compare_irq;
    endproperty
    a_init_low: assert property (p_init_low)
        else $error("Mode write did not start pin low");

    property p_pwm_init;
        ctrl_wr && (new_mode == `OCC_MODE_PWM ||
        new_mode == `OCC_MODE_PWM_FLT) |=> compare_output_pin ==
        ($past(primary_compare_value) != `OCC_ZERO16);
    endproperty
    a_pwm_init: assert property (p_pwm_init)
        else $error("PWM start level wrong");

    property p_fault_hold;
        flt_mode && pwm_fault_flag && !ctrl_wr |=> !compare_output_pin;
    endproperty
    a_fault_hold: assert property (p_fault_hold)
        else $error("Pin not held low while fault latched");

endmodule // occ_output_compare

// ### occ_pkg.sv
// Types shared by the output compare channel.
// Assumes occ_map.svh supplies the address width.
`include "occ_map.svh"

package occ_pkg;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [`OCC_ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } occ_apb_req_s;

    typedef enum logic [1:0] {
        PULSE_WAIT_RISE,
        PULSE_WAIT_FALL,
        PULSE_DONE
    } occ_pulse_e;

endpackage

// ### tb_top.sv
// Testbench of the output compare channel: APB master, timer and fault
// stimulus, expected pin and event counts reckoned here.
// Assumes occ_map.svh, occ_pkg and the load model are compiled first.
`include "occ_map.svh"
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
    num_errors++; $display("[ERR] %0t got %h exp %h", $time, got, exp); \
    end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    occ_pkg::occ_apb_req_s req = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] t2 = 16'h0000;
    logic [15:0] t3 = 16'h0000;
    logic idle = 1'b0;
    logic fault_a_n = 1'b1;
    logic pin;
    logic drive_en;
    logic irq;
    logic load_level;
    logic [31:0] rd;
    logic err;
    logic [15:0] pri;
    logic [15:0] sec;
    int num_errors = 0;
    int checked = 0;
    int irq_n = 0;
    int exp_irq = 0;

    occ_output_compare i_occ_output_compare (.clk_sys(clk_sys),
        .reset_n(reset_n), .apb_req(req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer2_count(t2),
        .timer3_count(t3), .cpu_idle(idle), .fault_input_a(fault_a_n),
        .compare_output_pin(pin), .pin_drive_en(drive_en),
        .compare_irq(irq));
    occ_load_model i_occ_load_model (.clk_sys(clk_sys),
        .compare_output_pin(pin), .pin_drive_en(drive_en),
        .load_level(load_level));

    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (irq === 1'b1) irq_n <= irq_n + 1;
    end

    task automatic apb(input logic wr, input logic [7:0] addr,
                       input logic [31:0] data);
        @(posedge clk_sys);
        req <= '{1'b1, 1'b0, wr, addr, data};
        @(posedge clk_sys);
        req.penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        req <= '0;
    endtask
    task automatic ctrl(input logic [31:0] v);
        apb(1'b1, `OCC_ADDR_CTRL, v);
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic count_to(input logic [15:0] a, input logic [15:0] b);
        @(posedge clk_sys);
        t2 <= a;
        t3 <= b;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #(5 * 20000);
        num_errors++;
        conclude();
    end

    initial begin
        void'($urandom(11881));
        pri = 16'h0100 | 16'($urandom() & 32'h0000_00ff);
        sec = pri + 16'h0200;
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        apb(1'b0, `OCC_ADDR_CTRL, 32'h0);
        `CHK(rd, `OCC_ZERO32)
        apb(1'b1, `OCC_ADDR_CTRL, 32'hffff_fff8);
        apb(1'b0, `OCC_ADDR_CTRL, 32'h0);
        `CHK(rd, 32'h0000_2008)
        apb(1'b0, 8'h0c, 32'h0);
        `CHK(err, 1'b1)
        apb(1'b1, `OCC_ADDR_PRI, {16'h0000, pri});
        apb(1'b1, `OCC_ADDR_SEC, {16'h0000, sec});
        $display("test registers done");
        // Timer held still across every control write
        for (int m = 1; m <= 3; m++) begin
            count_to(16'h0000, 16'h0000);
            ctrl(m);
            `CHK(pin, (m == 2))
            `CHK(drive_en, 1'b1)
            count_to(pri, 16'h0000);
            exp_irq++;
            `CHK(pin, (m != 2))
            `CHK(irq_n, exp_irq)
        end
        count_to(16'h0000, 16'h0000);
        count_to(pri, 16'h0000);
        exp_irq++;
        `CHK(pin, 1'b0)
        `CHK(irq_n, exp_irq)
        $display("test single compare done");
        count_to(16'h0000, 16'h0000);
        ctrl(32'h0000_2009);
        idle <= 1'b1;
        count_to(pri, pri);
        `CHK(pin, 1'b0)
        idle <= 1'b0;
        count_to(pri, 16'h0000);
        `CHK(pin, 1'b0)
        count_to(16'h0000, pri);
        exp_irq++;
        `CHK(pin, 1'b1)
        count_to(16'h0000, 16'h0000);
        ctrl(32'h0000_0001);
        idle <= 1'b1;
        count_to(pri, 16'h0000);
        exp_irq++;
        `CHK(pin, 1'b1)
        `CHK(irq_n, exp_irq)
        idle <= 1'b0;
        $display("test select and idle done");
        for (int m = 4; m <= 5; m++) begin
            count_to(16'h0000, 16'h0000);
            ctrl(m);
            `CHK(pin, 1'b0)
            for (int r = 0; r < 2; r++) begin
                count_to(pri, 16'h0000);
                `CHK(pin, (r == 0 || m == 5))
                count_to(sec, 16'h0000);
                if (r == 0 || m == 5) exp_irq++;
                `CHK(pin, 1'b0)
                `CHK(irq_n, exp_irq)
            end
        end
        $display("test pulse done");
        count_to(16'h0000, 16'h0000);
        apb(1'b1, `OCC_ADDR_PRI, 32'h0);
        ctrl(32'h0000_0006);
        `CHK(pin, 1'b0)
        apb(1'b1, `OCC_ADDR_PRI, {16'h0000, pri});
        apb(1'b1, `OCC_ADDR_SEC, {16'h0000, pri});
        ctrl(32'h0000_0006);
        `CHK(pin, 1'b1)
        count_to(pri, 16'h0000);
        `CHK(pin, 1'b0)
        count_to(16'h0000, 16'h0000);
        `CHK(pin, 1'b1)
        `CHK(irq_n, exp_irq)
        ctrl(32'h0000_0007);
        `CHK(pin, 1'b1)
        @(posedge clk_sys);
        fault_a_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        exp_irq++;
        `CHK(pin, 1'b0)
        `CHK(irq_n, exp_irq)
        apb(1'b0, `OCC_ADDR_CTRL, 32'h0);
        `CHK(rd[4], 1'b1)
        fault_a_n <= 1'b1;
        count_to(pri, 16'h0000);
        count_to(16'h0000, 16'h0000);
        apb(1'b0, `OCC_ADDR_CTRL, 32'h0);
        `CHK(rd[4], 1'b0)
        // Pin stays low through the clearing period, resumes at the next
        count_to(pri, 16'h0000);
        count_to(16'h0000, 16'h0000);
        `CHK(pin, 1'b1)
        ctrl(32'h0000_0000);
        `CHK(drive_en, 1'b0)
        @(posedge clk_sys);
        `CHK(load_level, 1'b0)
        $display("test pwm done");
        conclude();
    end
endmodule // tb_top
